// [hdl/switch_forwarding_policy.sv]
// Forwarding decision with tail tag, IGMP trap, mirroring and rate limits.
//
// Overview of operation
// - Tail tag only on processor port 3.
// - Host tag bits 1:0 select destination ports.
// - Host tag bits 3:2 give frame priority.
// - Host-bound tag bit 0 names ingress port.
// - Other tag bits are ignored.
// - Tag handling only when tail-tag enable set.
// - Strip tag before sending on PHY port.
// - Trap IPv4 protocol 2 frames to port 3.
// - Receive sniff copies received frames to sniffer.
// - Transmit sniff copies forwarded frames to sniffer.
// - Mirror-AND needs both receive and transmit match.
// - Many sniff sources, any port is sniffer.
// - Rates 64 kbps steps, then 1 Mbps steps.
// - Limits per port and priority, both directions.
// - On 10BASE-T above 10 Mbps means unlimited.
// - Counted length DA..FCS plus optional IFG, preamble.
// - Ingress counts chosen classes, drops when exceeded.
// - Egress leaky bucket stretches gaps between frames.
// - Full queue memory drops or asserts flow control.
// - Unknown unicast filtered or forwarded by setting.
`timescale 1ns/1ps
`default_nettype none
`include "fwd_policy_cfg.svh"

module desc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Fill side.
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [WIDTH-1:0] IN_DATA,
    // Drain side.
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [WIDTH-1:0] OUT_DATA
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign IN_READY = (count_reg != DEPTH[AW:0]);
    assign OUT_VALID = (count_reg != '0);
    assign OUT_DATA = mem[rd_reg];
    assign push = IN_VALID && IN_READY;
    assign pop = OUT_VALID && OUT_READY;

    always_ff @(posedge CLK) begin
        if (push) begin
            mem[wr_reg] <= IN_DATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module switch_forwarding_policy #(
    parameter int WINDOW_CYCLES = `WINDOW_CYCLES_DEF
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Frame descriptor from the receive MACs; port index 0..2 = ports 1..3.
    input wire logic DESC_VALID,
    output logic DESC_READY,
    input wire logic [1:0] DESC_PORT,
    input wire logic [2:0] DESC_LOOKUP,
    input wire logic [7:0] DESC_TAG,
    input wire logic [1:0] DESC_PRIO,
    input wire logic [10:0] DESC_LEN,
    input wire logic DESC_IS_IP,
    input wire logic [3:0] DESC_IP_VER,
    input wire logic [7:0] DESC_IP_PROTO,
    input wire logic DESC_UNKNOWN_UC,
    input wire logic DESC_MCAST,
    input wire logic DESC_BCAST,
    input wire logic DESC_FLOOD_UC,
    input wire logic DESC_BAD,
    // Configuration.
    input wire logic TAIL_TAG_EN,
    input wire logic MIRROR_AND,
    input wire logic MIRROR_BAD,
    input wire logic [2:0] RX_SNIFF,
    input wire logic [2:0] TX_SNIFF,
    input wire logic [2:0] SNIFFER,
    input wire logic UNKNOWN_UC_FWD,
    input wire logic [2:0] SPEED_10,
    input wire logic ADD_IFG,
    input wire logic ADD_PREAMBLE,
    input wire logic [3:0] ING_CLASS,
    input wire logic [83:0] ING_RATE,
    input wire logic [83:0] EGR_RATE,
    input wire logic FC_NOT_DROP,
    // Queue memory state from the buffer manager.
    input wire logic [2:0] QUEUE_FULL,
    // Decision out.
    output logic DEC_VALID,
    input wire logic DEC_READY,
    output logic [2:0] DEC_MASK,
    output logic [1:0] DEC_PRIO,
    output logic DEC_STRIP_TAG,
    output logic DEC_ADD_TAG,
    output logic [7:0] DEC_HOST_TAG,
    output logic DEC_DROP,
    output logic FLOW_CTRL
);
    logic head_valid, head_ready;
    logic [`DESC_W-1:0] head;
    logic [1:0] h_port, h_prio;
    logic [2:0] h_lookup;
    logic [7:0] h_tag, h_proto;
    logic [10:0] h_len;
    logic [3:0] h_ver;
    logic h_is_ip, h_unk, h_mc, h_bc, h_fl, h_bad;

    desc_fifo #(.WIDTH(`DESC_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .IN_VALID(DESC_VALID),
        .IN_READY(DESC_READY),
        .IN_DATA({DESC_PORT, DESC_LOOKUP, DESC_TAG, DESC_PRIO, DESC_LEN,
                  DESC_IS_IP, DESC_IP_VER, DESC_IP_PROTO, DESC_UNKNOWN_UC,
                  DESC_MCAST, DESC_BCAST, DESC_FLOOD_UC, DESC_BAD}),
        .OUT_VALID(head_valid),
        .OUT_READY(head_ready),
        .OUT_DATA(head)
    );

    assign {h_port, h_lookup, h_tag, h_prio, h_len, h_is_ip, h_ver, h_proto,
            h_unk, h_mc, h_bc, h_fl, h_bad} = head;

    // Bytes a window of the given rate code may carry; zero means no limit.
    function automatic fwd_policy_pkg::level_type allow_bytes(
        input fwd_policy_pkg::rate_code_type code, input logic slow);
        fwd_policy_pkg::level_type r;
        r = '0;
        if (code >= `KBPS_CODE_MIN && code <= `KBPS_CODE_MAX) begin
            r = 16'(code - `KBPS_CODE_MIN + 7'h01) * `BYTES_PER_MS_64K;
        end else if (code != 7'h00 && code <= `MBPS_CODE_MAX) begin
            r = 16'(code) * `BYTES_PER_MS_MBPS;
            if (slow && code > `MBPS_10BT_MAX) begin
                r = '0;
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] bidx(input logic [1:0] p,
                                        input logic [1:0] q);
        return {p, q};
    endfunction

    fwd_policy_pkg::level_type ing_reg [0:`NBUCKET-1];
    fwd_policy_pkg::level_type egr_reg [0:`NBUCKET-1];
    logic [31:0] win_reg;
    fwd_policy_pkg::len_type cost;
    logic tick, tagged_in, igmp, rx_hit, tx_hit, mirror, class_hit;
    logic ing_over, stall, take;
    logic [1:0] prio;
    logic [2:0] fwd_mask, egr_over, full_hit, final_mask;
    logic [3:0] ib;

    assign tick = (win_reg == 32'(WINDOW_CYCLES - 1));

    always_ff @(posedge CLK) begin
        if (SYS_RST || tick) begin
            win_reg <= '0;
        end else begin
            win_reg <= win_reg + 32'h1;
        end
    end

    // Counted length runs DA..FCS, optionally plus gap and preamble.
    assign cost = h_len + (ADD_IFG ? `IFG_BYTES : 11'h000)
                  + (ADD_PREAMBLE ? `PREAMBLE_BYTES : 11'h000);

    // Tag only on port 3 and only while enabled; unused bits never read.
    assign tagged_in = TAIL_TAG_EN && h_port == `PORT_HOST;
    assign igmp = h_is_ip && h_ver == `IGMP_IP_VER
                  && h_proto == `IGMP_PROTO && h_port != `PORT_HOST;
    assign prio = tagged_in ? h_tag[`TAG_PRI_LSB +: 2] : h_prio;
    assign ib = bidx(h_port, prio);

    always_comb begin
        if (tagged_in && h_tag[`TAG_DST_LSB +: 2] != `TAG_DST_NORMAL) begin
            fwd_mask = {1'b0, h_tag[`TAG_DST_LSB +: 2]};
        end else if (igmp) begin
            fwd_mask = `MASK_HOST;
        end else if (h_unk && !UNKNOWN_UC_FWD) begin
            fwd_mask = 3'h0;
        end else begin
            fwd_mask = h_lookup & ~(3'h1 << h_port);
        end
        if (h_bad) begin
            fwd_mask = 3'h0;
        end
    end

    assign rx_hit = RX_SNIFF[h_port] && (!h_bad || MIRROR_BAD);
    assign tx_hit = |(fwd_mask & TX_SNIFF);
    assign mirror = MIRROR_AND ? (rx_hit && tx_hit)
                               : (rx_hit || tx_hit);

    assign class_hit = ING_CLASS[0] || (ING_CLASS[1] && h_mc)
                       || (ING_CLASS[2] && h_bc)
                       || (ING_CLASS[3] && h_fl);
    always_comb begin
        fwd_policy_pkg::level_type a;
        a = allow_bytes(ING_RATE[ib*7 +: 7], SPEED_10[h_port]);
        ing_over = class_hit && a != '0 && ing_reg[ib] >= a;
    end

    // A shaped queue holds its frame until the bucket drains below limit.
    always_comb begin
        fwd_policy_pkg::level_type a;
        a = '0;
        for (int p = 0; p < `NPORT; p++) begin
            a = allow_bytes(EGR_RATE[bidx(2'(p), prio)*7 +: 7], SPEED_10[p]);
            egr_over[p] = a != '0 && egr_reg[bidx(2'(p), prio)] >= a;
        end
    end

    always_comb begin
        final_mask = ing_over ? 3'h0 : fwd_mask;
        if (mirror && !ing_over) begin
            final_mask = final_mask | (SNIFFER & ~(3'h1 << h_port));
        end
        full_hit = final_mask & QUEUE_FULL;
        if (!FC_NOT_DROP) begin
            final_mask = final_mask & ~QUEUE_FULL;
        end
    end

    assign stall = |(final_mask & egr_over)
                   || (FC_NOT_DROP && full_hit != 3'h0);
    assign head_ready = head_valid && !stall && (!DEC_VALID || DEC_READY);
    assign take = head_ready;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            FLOW_CTRL <= 1'b0;
        end else begin
            FLOW_CTRL <= head_valid && FC_NOT_DROP && full_hit != 3'h0;
        end
    end

    // A frame charged in a window edge still counts; the leak runs first.
    // An unlimited bucket empties, so a limit enabled later starts fresh.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < `NBUCKET; i++) begin
                ing_reg[i] <= '0;
                egr_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < `NBUCKET; i++) begin
                logic [16:0] ni;
                logic [16:0] ne;
                fwd_policy_pkg::level_type ai;
                fwd_policy_pkg::level_type ae;
                ai = allow_bytes(ING_RATE[i*7 +: 7], SPEED_10[i/4]);
                ae = allow_bytes(EGR_RATE[i*7 +: 7], SPEED_10[i/4]);
                ni = {1'b0, ing_reg[i]};
                ne = {1'b0, egr_reg[i]};
                if (tick) begin
                    ni = (ni > {1'b0, ai} && ai != '0) ? ni - {1'b0, ai}
                                                       : 17'h0;
                    ne = (ne > {1'b0, ae} && ae != '0) ? ne - {1'b0, ae}
                                                       : 17'h0;
                end
                if (take && !ing_over && class_hit && 4'(i) == ib) begin
                    ni = ni + {6'h00, cost};
                end
                if (take && final_mask[i/4] && 2'(i % 4) == prio) begin
                    ne = ne + {6'h00, cost};
                end
                ing_reg[i] <= ni[16] ? `LEVEL_MAX : ni[15:0];
                egr_reg[i] <= ne[16] ? `LEVEL_MAX : ne[15:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            DEC_VALID <= 1'b0;
        end else if (take) begin
            DEC_VALID <= 1'b1;
        end else if (DEC_READY) begin
            DEC_VALID <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            DEC_MASK <= 3'h0;
            DEC_PRIO <= 2'h0;
            DEC_STRIP_TAG <= 1'b0;
            DEC_ADD_TAG <= 1'b0;
            DEC_HOST_TAG <= 8'h00;
            DEC_DROP <= 1'b0;
        end else if (take) begin
            DEC_MASK <= final_mask;
            DEC_PRIO <= prio;
            // The tag byte before the FCS is removed for PHY ports.
            DEC_STRIP_TAG <= tagged_in && final_mask[1:0] != 2'h0;
            DEC_ADD_TAG <= TAIL_TAG_EN && final_mask[`PORT_HOST];
            DEC_HOST_TAG <= {7'h00, h_port == `PORT_P2};
            DEC_DROP <= final_mask == 3'h0;
        end
    end

    sequence s_take;
        take;
    endsequence

    property p_strip;
        @(posedge CLK) disable iff (SYS_RST)
        s_take ##1 DEC_STRIP_TAG |-> $past(h_port) == `PORT_HOST
            && $past(TAIL_TAG_EN);
    endproperty
    a_strip: assert property (p_strip) else $error("strip wrong");

    property p_dest;
        @(posedge CLK) disable iff (SYS_RST)
        s_take and tagged_in && h_tag[1:0] != 2'h0 && !h_bad && !ing_over
            && !mirror && !FC_NOT_DROP && QUEUE_FULL == 3'h0
        |=> DEC_MASK == {1'b0, $past(h_tag[1:0])};
    endproperty
    a_dest: assert property (p_dest) else $error("tag dest wrong");

    property p_prio;
        @(posedge CLK) disable iff (SYS_RST)
        s_take and tagged_in |=> DEC_PRIO == $past(h_tag[3:2]);
    endproperty
    a_prio: assert property (p_prio) else $error("tag prio wrong");

    property p_src;
        @(posedge CLK) disable iff (SYS_RST)
        s_take |=> DEC_HOST_TAG[0] == ($past(h_port) == 2'h1)
            && DEC_HOST_TAG[7:1] == 7'h00;
    endproperty
    a_src: assert property (p_src) else $error("source bit wrong");

    property p_off;
        @(posedge CLK) disable iff (SYS_RST)
        s_take and !TAIL_TAG_EN |=> !DEC_STRIP_TAG && !DEC_ADD_TAG;
    endproperty
    a_off: assert property (p_off) else $error("tag used off");

    property p_igmp;
        @(posedge CLK) disable iff (SYS_RST)
        s_take and igmp && !tagged_in && !h_bad && !ing_over && !mirror
            && QUEUE_FULL == 3'h0 |=> DEC_MASK == 3'h4;
    endproperty
    a_igmp: assert property (p_igmp) else $error("igmp not trapped");

    property p_and;
        @(posedge CLK) disable iff (SYS_RST)
        s_take and MIRROR_AND && !(rx_hit && tx_hit) && !ing_over
            && QUEUE_FULL == 3'h0 |=> DEC_MASK == $past(fwd_mask);
    endproperty
    a_and: assert property (p_and) else $error("mirror and wrong");

    property p_unk;
        @(posedge CLK) disable iff (SYS_RST)
        s_take and h_unk && !UNKNOWN_UC_FWD && !igmp && !tagged_in
            && !mirror |=> DEC_DROP;
    endproperty
    a_unk: assert property (p_unk) else $error("unknown uc passed");
endmodule
`default_nettype wire

// [hdl/fwd_policy_cfg.svh]
// Constants of the switch forwarding-policy block.
`ifndef FWD_POLICY_CFG_SVH
`define FWD_POLICY_CFG_SVH
`define CLK_MHZ 10
`define RATE_WINDOW_US 1000
`define WINDOW_CYCLES_DEF (`RATE_WINDOW_US * `CLK_MHZ)
`define NPORT 3
`define NPRIO 4
`define NBUCKET 12
`define PORT_HOST 2'h2
`define PORT_P2 2'h1
`define TAG_DST_LSB 0
`define TAG_PRI_LSB 2
`define TAG_DST_NORMAL 2'h0
`define MASK_HOST 3'h4
`define IGMP_IP_VER 4'h4
`define IGMP_PROTO 8'h02
`define KBPS_CODE_MIN 7'h64
`define KBPS_CODE_MAX 7'h72
`define MBPS_CODE_MAX 7'h63
`define MBPS_10BT_MAX 7'h0a
`define BYTES_PER_MS_MBPS 16'h007d
`define BYTES_PER_MS_64K 16'h0008
`define IFG_BYTES 11'h00c
`define PREAMBLE_BYTES 11'h008
`define LEVEL_MAX 16'hffff
`define DESC_W 44
`define FIFO_DEPTH 4
`endif

// [hdl/fwd_policy_pkg.sv]
// Types shared by the forwarding-policy block.
package fwd_policy_pkg;
    typedef logic [2:0] port_mask_type;
    typedef logic [1:0] port_idx_type;
    typedef logic [6:0] rate_code_type;
    typedef logic [15:0] level_type;
    typedef logic [10:0] len_type;
endpackage

// [verification/dec_sink.sv]
// Decision consumer model standing at the egress side of the policy block.
`timescale 1ns/1ps
`default_nettype none
module dec_sink (
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Decision bus.
    input wire logic DEC_VALID,
    output logic DEC_READY,
    input wire logic [2:0] DEC_MASK,
    input wire logic [1:0] DEC_PRIO,
    input wire logic DEC_STRIP_TAG,
    input wire logic DEC_ADD_TAG,
    input wire logic [7:0] DEC_HOST_TAG,
    input wire logic DEC_DROP,
    // Test control and record.
    input wire logic STALL,
    output logic [15:0] LAST,
    output int COUNT
);
    // Ready moves on the falling edge so the design samples it settled.
    always @(negedge CLK) begin
        DEC_READY <= !STALL && !SYS_RST;
    end
    always @(posedge CLK) begin
        if (SYS_RST) begin
            COUNT <= 0;
            LAST <= 16'h0000;
        end else if (DEC_VALID && DEC_READY) begin
            COUNT <= COUNT + 1;
            LAST <= {DEC_MASK, DEC_PRIO, DEC_STRIP_TAG, DEC_ADD_TAG,
                     DEC_HOST_TAG, DEC_DROP};
        end
    end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the forwarding-policy block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin \
    failures++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb;
    logic CLK, SYS_RST, DESC_VALID, DESC_READY, DESC_IS_IP, DESC_BAD;
    logic DESC_UNKNOWN_UC, DESC_MCAST, TAIL_TAG_EN, MIRROR_AND, MIRROR_BAD;
    logic UNKNOWN_UC_FWD, FC_NOT_DROP, DEC_VALID, DEC_READY, DEC_STRIP_TAG;
    logic DEC_ADD_TAG, DEC_DROP, FLOW_CTRL, stall, ADD_IFG, ADD_PREAMBLE;
    logic DESC_BCAST, DESC_FLOOD_UC;
    logic [1:0] DESC_PORT, DESC_PRIO, DEC_PRIO;
    logic [2:0] DESC_LOOKUP, RX_SNIFF, TX_SNIFF, SNIFFER, SPEED_10;
    logic [2:0] QUEUE_FULL, DEC_MASK;
    logic [3:0] DESC_IP_VER, ING_CLASS;
    logic [7:0] DESC_TAG, DESC_IP_PROTO, DEC_HOST_TAG;
    logic [10:0] DESC_LEN;
    logic [83:0] ING_RATE, EGR_RATE;
    logic [15:0] dec_last;
    int dec_count, want_count, failures, total_checks;

    // The rate window is shortened so the leaky buckets act within the run.
    switch_forwarding_policy #(.WINDOW_CYCLES(50))
    switch_forwarding_policy_inst (
        .CLK(CLK), .SYS_RST(SYS_RST), .DESC_VALID(DESC_VALID),
        .DESC_READY(DESC_READY), .DESC_PORT(DESC_PORT),
        .DESC_LOOKUP(DESC_LOOKUP), .DESC_TAG(DESC_TAG),
        .DESC_PRIO(DESC_PRIO), .DESC_LEN(DESC_LEN), .DESC_IS_IP(DESC_IS_IP),
        .DESC_IP_VER(DESC_IP_VER), .DESC_IP_PROTO(DESC_IP_PROTO),
        .DESC_UNKNOWN_UC(DESC_UNKNOWN_UC), .DESC_MCAST(DESC_MCAST),
        .DESC_BCAST(DESC_BCAST), .DESC_FLOOD_UC(DESC_FLOOD_UC),
        .DESC_BAD(DESC_BAD),
        .TAIL_TAG_EN(TAIL_TAG_EN), .MIRROR_AND(MIRROR_AND),
        .MIRROR_BAD(MIRROR_BAD), .RX_SNIFF(RX_SNIFF), .TX_SNIFF(TX_SNIFF),
        .SNIFFER(SNIFFER), .UNKNOWN_UC_FWD(UNKNOWN_UC_FWD),
        .SPEED_10(SPEED_10), .ADD_IFG(ADD_IFG), .ADD_PREAMBLE(ADD_PREAMBLE),
        .ING_CLASS(ING_CLASS), .ING_RATE(ING_RATE), .EGR_RATE(EGR_RATE),
        .FC_NOT_DROP(FC_NOT_DROP), .QUEUE_FULL(QUEUE_FULL),
        .DEC_VALID(DEC_VALID), .DEC_READY(DEC_READY), .DEC_MASK(DEC_MASK),
        .DEC_PRIO(DEC_PRIO), .DEC_STRIP_TAG(DEC_STRIP_TAG),
        .DEC_ADD_TAG(DEC_ADD_TAG), .DEC_HOST_TAG(DEC_HOST_TAG),
        .DEC_DROP(DEC_DROP), .FLOW_CTRL(FLOW_CTRL));

    dec_sink dec_sink_inst (
        .CLK(CLK), .SYS_RST(SYS_RST), .DEC_VALID(DEC_VALID),
        .DEC_READY(DEC_READY), .DEC_MASK(DEC_MASK), .DEC_PRIO(DEC_PRIO),
        .DEC_STRIP_TAG(DEC_STRIP_TAG), .DEC_ADD_TAG(DEC_ADD_TAG),
        .DEC_HOST_TAG(DEC_HOST_TAG), .DEC_DROP(DEC_DROP), .STALL(stall),
        .LAST(dec_last), .COUNT(dec_count));

    // An empty mask always means the frame is dropped.
    function automatic logic [15:0] ex(input logic [2:0] m,
        input logic [1:0] p = 2'h0, input logic s = 1'b0,
        input logic a = 1'b0, input logic [7:0] h = 8'h00);
        return {m, p, s, a, h, m == 3'h0};
    endfunction

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic give_up(input string m);
        failures++;
        $display("MISMATCH t=%0t timeout in %s", $time, m);
        report_and_stop;
    endtask

    task automatic offer(input logic [1:0] p, input logic [2:0] l,
        input logic [7:0] t);
        int n;
        n = 0;
        {DESC_PORT, DESC_LOOKUP, DESC_TAG, DESC_VALID} = {p, l, t, 1'b1};
        while (DESC_READY !== 1'b1 && n < 50) begin
            @(negedge CLK);
            n++;
        end
        if (n == 50) give_up("offer");
        @(negedge CLK);
        DESC_VALID = 1'b0;
        want_count++;
    endtask

    task automatic await(input logic [15:0] e);
        int n;
        n = 0;
        while (dec_count < want_count && n < 100) begin
            @(negedge CLK);
            n++;
        end
        if (n == 100) give_up("decision");
        `CHK(dec_last, e, "decision fields")
        `CHK(dec_count, want_count, "decision count")
    endtask

    task automatic decide(input logic [1:0] p, input logic [2:0] l,
        input logic [7:0] t, input logic [15:0] e);
        offer(p, l, t);
        // Every decision on a port-2 frame reports that source in bit 0 of the host tag byte.
        await(e | {14'h0000, p == 2'h1, 1'b0});
    endtask

    task automatic rate_scenario;
        {ING_CLASS, SPEED_10, DESC_LEN} = {4'h1, 3'h2, 11'h5dc};
        ING_RATE[6:0] = 7'h64;
        ING_RATE[34:28] = 7'h0b;
        decide(2'h0, 3'h2, 8'h00, ex(3'h2));
        decide(2'h0, 3'h2, 8'h00, ex(3'h0));
        decide(2'h1, 3'h1, 8'h00, ex(3'h1));
        decide(2'h1, 3'h1, 8'h00, ex(3'h1));
        ING_CLASS = 4'h2;
        decide(2'h0, 3'h2, 8'h00, ex(3'h2));
        DESC_MCAST = 1'b1;
        decide(2'h0, 3'h2, 8'h00, ex(3'h0));
        {DESC_MCAST, DESC_BCAST, ING_CLASS} = {1'b0, 1'b1, 4'h4};
        decide(2'h0, 3'h2, 8'h00, ex(3'h0));
        {DESC_BCAST, DESC_FLOOD_UC, ING_CLASS} = {1'b0, 1'b1, 4'h8};
        decide(2'h0, 3'h2, 8'h00, ex(3'h0));
        {DESC_FLOOD_UC, ING_CLASS, ING_RATE} = {1'b0, 4'h0, 84'h0};
        DESC_LEN = 11'h040;
    endtask

    task automatic tag_scenario;
        logic [1:0] i;
        logic [15:0] e;
        TAIL_TAG_EN = 1'b1;
        // Upper tag bits carry junk that must not leak into the decision.
        for (int k = 0; k < 4; k++) begin
            i = 2'(k);
            e = ex(i == 2'h0 ? 3'h3 : {1'b0, i}, i, 1'b1);
            decide(2'h2, 3'h3, {4'hb, i, i}, e);
        end
        // The host answers toward port 2 although lookup reaches no port.
        decide(2'h2, 3'h0, 8'h02, ex(3'h2, 2'h0, 1'b1));
        decide(2'h0, 3'h4, 8'hff, ex(3'h4, 2'h0, 1'b0, 1'b1));
        decide(2'h1, 3'h4, 8'hff, ex(3'h4, 2'h0, 1'b0, 1'b1, 8'h01));
        decide(2'h0, 3'h2, 8'h03, ex(3'h2));
        {TAIL_TAG_EN, DESC_PRIO} = {1'b0, 2'h3};
        decide(2'h2, 3'h2, 8'h05, ex(3'h2, 2'h3));
        decide(2'h1, 3'h4, 8'h00, ex(3'h4, 2'h3));
        DESC_PRIO = 2'h0;
    endtask

    task automatic igmp_scenario;
        {DESC_IS_IP, DESC_IP_VER, DESC_IP_PROTO} = {1'b1, 4'h4, 8'h02};
        decide(2'h0, 3'h3, 8'h00, ex(3'h4));
        decide(2'h1, 3'h1, 8'h00, ex(3'h4));
        DESC_IP_PROTO = 8'h06;
        decide(2'h0, 3'h2, 8'h00, ex(3'h2));
        {DESC_IP_VER, DESC_IP_PROTO} = {4'h6, 8'h02};
        decide(2'h0, 3'h2, 8'h00, ex(3'h2));
        {DESC_IS_IP, DESC_IP_VER} = {1'b0, 4'h4};
        decide(2'h0, 3'h2, 8'h00, ex(3'h2));
    endtask

    task automatic mirror_scenario;
        {RX_SNIFF, SNIFFER} = {3'h1, 3'h4};
        decide(2'h0, 3'h2, 8'h00, ex(3'h6));
        decide(2'h1, 3'h1, 8'h00, ex(3'h1));
        {DESC_BAD, MIRROR_BAD} = 2'h3;
        decide(2'h0, 3'h2, 8'h00, ex(3'h4));
        MIRROR_BAD = 1'b0;
        decide(2'h0, 3'h2, 8'h00, ex(3'h0));
        {DESC_BAD, RX_SNIFF, TX_SNIFF} = {1'b0, 3'h0, 3'h1};
        decide(2'h1, 3'h1, 8'h00, ex(3'h5));
        decide(2'h2, 3'h2, 8'h00, ex(3'h2));
        {MIRROR_AND, RX_SNIFF, TX_SNIFF} = {1'b1, 3'h1, 3'h2};
        decide(2'h0, 3'h2, 8'h00, ex(3'h6));
        decide(2'h0, 3'h4, 8'h00, ex(3'h4));
        decide(2'h2, 3'h2, 8'h00, ex(3'h2));
        {MIRROR_AND, RX_SNIFF, TX_SNIFF, SNIFFER} = {1'b0, 3'h5, 3'h0, 3'h2};
        decide(2'h2, 3'h1, 8'h00, ex(3'h3));
        decide(2'h0, 3'h4, 8'h00, ex(3'h6));
        {RX_SNIFF, SNIFFER} = 6'h00;
    endtask

    task automatic uc_queue_scenario;
        DESC_UNKNOWN_UC = 1'b1;
        decide(2'h0, 3'h6, 8'h00, ex(3'h0));
        UNKNOWN_UC_FWD = 1'b1;
        decide(2'h0, 3'h6, 8'h00, ex(3'h6));
        {DESC_UNKNOWN_UC, QUEUE_FULL} = {1'b0, 3'h2};
        decide(2'h0, 3'h2, 8'h00, ex(3'h0));
        FC_NOT_DROP = 1'b1;
        offer(2'h0, 3'h2, 8'h00);
        repeat (4) @(negedge CLK);
        `CHK(FLOW_CTRL, 1'b1, "flow control raised")
        `CHK(dec_count, want_count - 1, "head held")
        QUEUE_FULL = 3'h0;
        await(ex(3'h2));
        FC_NOT_DROP = 1'b0;
    endtask

    // Eight bytes leak per window, so an 84-byte charge holds ten windows.
    task automatic egress_scenario;
        {EGR_RATE[13:7], DESC_PRIO, ADD_IFG, ADD_PREAMBLE} = {7'h64, 2'h1, 2'h3};
        decide(2'h1, 3'h1, 8'h00, ex(3'h1, 2'h1));
        offer(2'h1, 3'h1, 8'h00);
        repeat (400) @(negedge CLK);
        `CHK(dec_count, want_count - 1, "shaped frame held")
        repeat (150) @(negedge CLK);
        await(ex(3'h1, 2'h1, 1'b0, 1'b0, 8'h01));
        {EGR_RATE, DESC_PRIO, ADD_IFG, ADD_PREAMBLE} = '0;
    endtask

    task automatic fifo_scenario;
        int n;
        n = 0;
        stall = 1'b1;
        repeat (2) @(negedge CLK);
        {DESC_PORT, DESC_LOOKUP, DESC_VALID} = {2'h1, 3'h1, 1'b1};
        for (int k = 0; k < 8; k++) begin
            if (DESC_READY === 1'b1) n++;
            @(negedge CLK);
        end
        DESC_VALID = 1'b0;
        `CHK(DESC_READY, 1'b0, "full queue refuses")
        `CHK(n >= 4 && n <= 5, 1'b1, "queue depth")
        want_count += n;
        stall = 1'b0;
        await(ex(3'h1, 2'h0, 1'b0, 1'b0, 8'h01));
        `CHK(DESC_READY, 1'b1, "drained queue accepts")
    endtask

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    initial begin
        {DESC_VALID, DESC_IS_IP, DESC_BAD, DESC_UNKNOWN_UC, DESC_MCAST} = '0;
        {TAIL_TAG_EN, MIRROR_AND, MIRROR_BAD, UNKNOWN_UC_FWD} = '0;
        {FC_NOT_DROP, stall, DESC_PORT, DESC_PRIO, DESC_LOOKUP} = '0;
        {RX_SNIFF, TX_SNIFF, SNIFFER, SPEED_10, QUEUE_FULL} = '0;
        {DESC_IP_VER, ING_CLASS, DESC_TAG, DESC_IP_PROTO, ING_RATE} = '0;
        {want_count, failures, total_checks} = '0;
        {ADD_IFG, ADD_PREAMBLE, DESC_BCAST, DESC_FLOOD_UC, EGR_RATE} = '0;
        DESC_LEN = 11'h040;
        SYS_RST = 1'b1;
        repeat (8) @(negedge CLK);
        SYS_RST = 1'b0;
        @(negedge CLK);
        `CHK({DEC_VALID, FLOW_CTRL, DESC_READY}, 3'h1, "idle after reset")
        rate_scenario;
        tag_scenario;
        igmp_scenario;
        mirror_scenario;
        uc_queue_scenario;
        egress_scenario;
        fifo_scenario;
        report_and_stop;
    end
endmodule
`default_nettype wire
